// *** hw/sidr_defs.svh ***
// Constants for the sensor identity register bank.
`ifndef SIDR_DEFS_SVH
`define SIDR_DEFS_SVH
// ****************************************
// Register pointer values
// ****************************************
`define SIDR_PTR_SER_HI 8'hfb
`define SIDR_PTR_SER_MID 8'hfc
`define SIDR_PTR_SER_LO 8'hfd
`define SIDR_PTR_MAKER 8'hfe
`define SIDR_PTR_PART 8'hff
// ****************************************
// Field positions and reset values
// ****************************************
`define SIDR_SER_HI_MSB 39
`define SIDR_SER_HI_LSB 24
`define SIDR_SER_MID_MSB 23
`define SIDR_SER_MID_LSB 8
`define SIDR_SER_LO_MSB 7
`define SIDR_SER_LO_LSB 0
`define SIDR_LO_FIELD_LSB 7
`define SIDR_PTR_RESET 8'h00
`define SIDR_DATA_RESET 16'h0000
// Arbitrary neutral identity values.
`define SIDR_MAKER_DEFAULT 16'h0a5c
`define SIDR_PART_DEFAULT 16'h0c3a
`define SIDR_SERIAL_DEFAULT 40'h0123456789
`endif

// *** hw/sidr_pkg.sv ***
// Types for the sensor identity register bank.
package sidr_pkg;
	typedef logic [7:0] sidr_ptr_t;
	typedef logic [15:0] sidr_word_t;
	typedef logic [39:0] sidr_serial_t;
	typedef enum logic [2:0] {
		SIDR_SEL_NONE,
		SIDR_SEL_SER_HI,
		SIDR_SEL_SER_MID,
		SIDR_SEL_SER_LO,
		SIDR_SEL_MAKER,
		SIDR_SEL_PART
	} sidr_sel_t;
	typedef struct packed {
		logic wr_ptr;
		logic wr_data;
		logic rd;
		sidr_ptr_t ptr;
		sidr_word_t wdata;
	} sidr_req_t;
	typedef struct packed {
		logic rd_valid;
		logic id_hit;
		sidr_word_t rdata;
	} sidr_rsp_t;
	typedef struct packed {
		sidr_ptr_t ptr;
		logic rd_valid;
		logic id_hit;
		sidr_word_t rdata;
	} sidr_state_t;
endpackage

// *** hw/sidr_word_mux.sv ***
// Selects the identity word that answers a given pointer.
`timescale 1ns/100ps
`include "sidr_defs.svh"
module sidr_word_mux
	import sidr_pkg::*;
(
	input wire sidr_ptr_t ptr_in,
	input wire sidr_serial_t serial_in,
	input wire sidr_word_t maker_in,
	input wire sidr_word_t part_in,
	output logic hit_out,
	output sidr_word_t word_out
);
	function automatic sidr_sel_t sidr_decode(input sidr_ptr_t p);
		case (p)
			`SIDR_PTR_SER_HI: sidr_decode = SIDR_SEL_SER_HI;
			`SIDR_PTR_SER_MID: sidr_decode = SIDR_SEL_SER_MID;
			`SIDR_PTR_SER_LO: sidr_decode = SIDR_SEL_SER_LO;
			`SIDR_PTR_MAKER: sidr_decode = SIDR_SEL_MAKER;
			`SIDR_PTR_PART: sidr_decode = SIDR_SEL_PART;
			default: sidr_decode = SIDR_SEL_NONE;
		endcase
	endfunction
	always_comb begin
		hit_out = 1'b1;
		case (sidr_decode(ptr_in))
			SIDR_SEL_SER_HI: word_out = serial_in[`SIDR_SER_HI_MSB:`SIDR_SER_HI_LSB]; // RL2
			SIDR_SEL_SER_MID: word_out = serial_in[`SIDR_SER_MID_MSB:`SIDR_SER_MID_LSB]; // RL3
			SIDR_SEL_SER_LO: word_out = {1'b0, serial_in[`SIDR_SER_LO_MSB:`SIDR_SER_LO_LSB],
				7'h00}; // RL4 RL5
			SIDR_SEL_MAKER: word_out = maker_in; // RL6
			SIDR_SEL_PART: word_out = part_in; // RL7
			default: begin
				word_out = `SIDR_DATA_RESET;
				hit_out = 1'b0;
			end
		endcase
	end
endmodule // sidr_word_mux

// *** hw/sidr_bank.sv ***
// Sensor identity register bank behind the register pointer.
// Summary of operation
// RL1: Unique 40-bit serial, read as three words.
// RL2: Pointer fb returns serial bits 39..24.
// RL3: Pointer fc returns serial bits 23..8.
// RL4: Pointer fd returns serial bits 7..0 in bits 14..7, bit 15 zero.
// RL5: Low seven bits of fd read zero.
// RL6: Pointer fe returns fixed maker code.
// RL7: Pointer ff returns fixed part code.
// RL8: Host acquires at most once per second.
// RL9: Eight-bit pointer, set by write, selects reads.
// RL10: Writes to identity registers are ignored.
`timescale 1ns/100ps
`include "sidr_defs.svh"
module sidr_bank
	import sidr_pkg::*;
#(
	parameter sidr_serial_t SERIAL = `SIDR_SERIAL_DEFAULT,
	parameter sidr_word_t MAKER_CODE = `SIDR_MAKER_DEFAULT,
	parameter sidr_word_t PART_CODE = `SIDR_PART_DEFAULT
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire sidr_req_t req_in,
	output sidr_rsp_t rsp_out,
	output sidr_ptr_t ptr_out
);
	// ****************************************
	// State
	// ****************************************
	sidr_state_t state_q;
	sidr_state_t state_d;
	logic hit;
	sidr_word_t word;
	sidr_ptr_t rd_ptr;

	// A read in the same cycle as a pointer write uses the new pointer.
	assign rd_ptr = req_in.wr_ptr ? req_in.ptr : state_q.ptr;

	sidr_word_mux u_mux (
		.ptr_in(rd_ptr),
		.serial_in(SERIAL),
		.maker_in(MAKER_CODE),
		.part_in(PART_CODE),
		.hit_out(hit),
		.word_out(word)
	);

	always_comb begin
		state_d = state_q;
		state_d.rd_valid = 1'b0;
		if (req_in.wr_ptr) begin
			state_d.ptr = req_in.ptr; // RL9
		end
		// Data writes are dropped: identity values are constants.
		if (req_in.rd) begin
			state_d.rd_valid = 1'b1;
			state_d.id_hit = hit;
			state_d.rdata = word; // RL1 RL9 RL10
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q <= '{ptr: `SIDR_PTR_RESET, rd_valid: 1'b0, id_hit: 1'b0,
				rdata: `SIDR_DATA_RESET};
		end else begin
			state_q <= state_d;
		end
	end

	assign rsp_out = '{rd_valid: state_q.rd_valid, id_hit: state_q.id_hit,
		rdata: state_q.rdata};
	assign ptr_out = state_q.ptr;

	// ****************************************
	// Checks
	// ****************************************
	property p_ser_hi;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.rd && rd_ptr == `SIDR_PTR_SER_HI) |=> rsp_out.rdata == SERIAL[39:24];
	endproperty
	a_ser_hi: assert property (p_ser_hi) else $error("high serial word wrong"); // RL2
	property p_ser_mid;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.rd && rd_ptr == `SIDR_PTR_SER_MID) |=> rsp_out.rdata == SERIAL[23:8];
	endproperty
	a_ser_mid: assert property (p_ser_mid) else $error("mid serial word wrong"); // RL3
	property p_ser_lo;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.rd && rd_ptr == `SIDR_PTR_SER_LO) |=>
			rsp_out.rdata[14:7] == SERIAL[7:0];
	endproperty
	a_ser_lo: assert property (p_ser_lo) else $error("low serial bits wrong"); // RL4
	property p_lo_rsvd;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.rd && rd_ptr == `SIDR_PTR_SER_LO) |=> rsp_out.rdata[6:0] == 7'h00;
	endproperty
	a_lo_rsvd: assert property (p_lo_rsvd) else $error("reserved bits not zero"); // RL5
	property p_maker;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.rd && rd_ptr == `SIDR_PTR_MAKER) |=> rsp_out.rdata == MAKER_CODE;
	endproperty
	a_maker: assert property (p_maker) else $error("maker code wrong"); // RL6
	property p_part;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.rd && rd_ptr == `SIDR_PTR_PART) |=> rsp_out.rdata == PART_CODE;
	endproperty
	a_part: assert property (p_part) else $error("part code wrong"); // RL7
	property p_ptr;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		req_in.wr_ptr |=> ptr_out == $past(req_in.ptr);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer not updated"); // RL9
	property p_nowr;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.wr_data && !req_in.rd) |=>
			$stable(rsp_out.rdata) && $stable(rsp_out.id_hit);
	endproperty
	a_nowr: assert property (p_nowr) else $error("write altered identity"); // RL10
	property p_valid;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		req_in.rd |=> rsp_out.rd_valid ##1 (rsp_out.rd_valid == $past(req_in.rd));
	endproperty
	a_valid: assert property (p_valid) else $error("read valid timing wrong"); // RL1

	// ****************************************
	// Decode checks
	// ****************************************
	property p_hit_id;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.rd && rd_ptr >= `SIDR_PTR_SER_HI) |=> rsp_out.id_hit;
	endproperty
	a_hit_id: assert property (p_hit_id) else $error("identity read not flagged"); // RL1

	property p_lo_top;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.rd && rd_ptr == `SIDR_PTR_SER_LO) |=> !rsp_out.rdata[15];
	endproperty
	a_lo_top: assert property (p_lo_top) else $error("low word top bit not zero"); // RL4

	property p_miss_data;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.rd && rd_ptr < `SIDR_PTR_SER_HI) |=> rsp_out.rdata == `SIDR_DATA_RESET;
	endproperty
	a_miss_data: assert property (p_miss_data) else $error("foreign pointer gave data"); // RL9

	property p_miss_hit;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.rd && rd_ptr < `SIDR_PTR_SER_HI) |=> !rsp_out.id_hit;
	endproperty
	a_miss_hit: assert property (p_miss_hit) else $error("foreign pointer flagged"); // RL9

	property p_idle_data;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		!rsp_out.id_hit |-> rsp_out.rdata == `SIDR_DATA_RESET;
	endproperty
	a_idle_data: assert property (p_idle_data) else $error("data without a hit"); // RL9

	// ****************************************
	// Pointer checks
	// ****************************************
	property p_ptr_hold;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		!req_in.wr_ptr |=> $stable(ptr_out);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved unasked"); // RL9

	property p_new_hit;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.wr_ptr && req_in.rd && req_in.ptr >= `SIDR_PTR_SER_HI) |=> rsp_out.id_hit;
	endproperty
	a_new_hit: assert property (p_new_hit) else $error("new pointer not used"); // RL9

	property p_new_maker;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.wr_ptr && req_in.rd && req_in.ptr == `SIDR_PTR_MAKER) |=>
			rsp_out.rdata == MAKER_CODE;
	endproperty
	a_new_maker: assert property (p_new_maker) else $error("maker code on new pointer"); // RL6

	property p_new_mid;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.wr_ptr && req_in.rd && req_in.ptr == `SIDR_PTR_SER_MID) |=>
			rsp_out.rdata == SERIAL[`SIDR_SER_MID_MSB:`SIDR_SER_MID_LSB];
	endproperty
	a_new_mid: assert property (p_new_mid) else $error("mid word on new pointer"); // RL3

	property p_new_lo;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.wr_ptr && req_in.rd && req_in.ptr == `SIDR_PTR_SER_LO) |=>
			rsp_out.rdata[6:0] == 7'h00;
	endproperty
	a_new_lo: assert property (p_new_lo) else $error("reserved bits on new pointer"); // RL5

	property p_old_part;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(!req_in.wr_ptr && req_in.rd && ptr_out == `SIDR_PTR_PART) |=>
			rsp_out.rdata == PART_CODE;
	endproperty
	a_old_part: assert property (p_old_part) else $error("part code on held pointer"); // RL7

	// ****************************************
	// Handshake checks
	// ****************************************
	property p_novalid;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		!req_in.rd |=> !rsp_out.rd_valid;
	endproperty
	a_novalid: assert property (p_novalid) else $error("valid without a read"); // RL9

	property p_hold_data;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		!req_in.rd |=> $stable(rsp_out.rdata);
	endproperty
	a_hold_data: assert property (p_hold_data) else $error("read data did not hold"); // RL9

	property p_hold_hit;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		!req_in.rd |=> $stable(rsp_out.id_hit);
	endproperty
	a_hold_hit: assert property (p_hold_hit) else $error("hit flag did not hold"); // RL9

	// ****************************************
	// Write checks
	// ****************************************
	property p_wr_novalid;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(req_in.wr_data && !req_in.rd) |=> !rsp_out.rd_valid;
	endproperty
	a_wr_novalid: assert property (p_wr_novalid) else $error("write raised valid"); // RL10
endmodule // sidr_bank

// *** test/sidr_host.sv ***
// Host model that sets the pointer, writes data and reads words.
`timescale 1ns/100ps
module sidr_host
	import sidr_pkg::*;
(
	input wire logic clk_sys_in,
	input wire sidr_rsp_t rsp_in,
	output sidr_req_t req_out
);
	initial req_out = '0;
	// ****************************************
	// Host accesses
	// ****************************************
	// Reads start no acquisition, so the rate limit is kept.
	task automatic rd(input sidr_ptr_t p, output sidr_word_t w, output logic h,
		output logic v);
		@(posedge clk_sys_in);
		req_out.wr_ptr <= 1'b1;
		req_out.ptr <= p;
		@(posedge clk_sys_in);
		req_out.wr_ptr <= 1'b0;
		req_out.rd <= 1'b1;
		@(posedge clk_sys_in);
		req_out.rd <= 1'b0;
		req_out.ptr <= ~p;
		#1;
		w = rsp_in.rdata;
		h = rsp_in.id_hit;
		v = rsp_in.rd_valid;
	endtask
	task automatic wr(input sidr_ptr_t p, input sidr_word_t d);
		@(posedge clk_sys_in);
		req_out.wr_ptr <= 1'b1;
		req_out.wr_data <= 1'b1;
		req_out.ptr <= p;
		req_out.wdata <= d;
		@(posedge clk_sys_in);
		req_out.wr_ptr <= 1'b0;
		req_out.wr_data <= 1'b0;
		req_out.wdata <= ~d;
	endtask
	task automatic rd_same(input sidr_ptr_t p, output sidr_word_t w, output logic h,
		output logic v);
		@(posedge clk_sys_in);
		req_out.wr_ptr <= 1'b1;
		req_out.rd <= 1'b1;
		req_out.ptr <= p;
		@(posedge clk_sys_in);
		req_out.wr_ptr <= 1'b0;
		req_out.rd <= 1'b0;
		req_out.ptr <= ~p;
		#1;
		w = rsp_in.rdata;
		h = rsp_in.id_hit;
		v = rsp_in.rd_valid;
	endtask
endmodule // sidr_host

// *** test/sidr_bank_tb.sv ***
// Testbench for the sensor identity register bank.
`timescale 1ns/100ps
module sidr_bank_tb;
	import sidr_pkg::*;
	localparam sidr_serial_t SER = 40'h9a5b3c7de1;
	// Arbitrary identity values.
	localparam sidr_word_t MK = 16'h1357;
	localparam sidr_word_t PT = 16'h2468;
	logic clk_sys_in = 1'b0;
	logic rstn_in = 1'b0;
	sidr_req_t req;
	sidr_rsp_t rsp;
	sidr_ptr_t ptr;
	sidr_word_t w;
	sidr_word_t exp_w [5];
	logic h;
	logic v;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	always #50 clk_sys_in = ~clk_sys_in;
	sidr_bank #(.SERIAL(SER), .MAKER_CODE(MK), .PART_CODE(PT)) uut (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.req_in(req),
		.rsp_out(rsp),
		.ptr_out(ptr)
	);
	sidr_host host (
		.clk_sys_in(clk_sys_in),
		.rsp_in(rsp),
		.req_out(req)
	);
	// ****************************************
	// Checking and verdict
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		if (bad_count == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 500) begin
			bad_count++;
			print_verdict();
		end
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		exp_w = '{SER[39:24], SER[23:8], {1'b0, SER[7:0], 7'h00}, MK, PT};
		repeat (12) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		#1;
		chk({8'h00, ptr}, 16'h0000);
		chk(rsp.rdata, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			host.rd(8'hfb + 8'(i), w, h, v);
			chk(w, exp_w[i]);
			chk({14'h0000, v, h}, 16'h0003);
			chk({8'h00, ptr}, {8'h00, 8'hfb + 8'(i)});
			host.wr(8'hfb + 8'(i), ~exp_w[i]);
			host.rd(8'hfb + 8'(i), w, h, v);
			chk(w, exp_w[i]);
		end
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk(rsp.rdata, exp_w[4]);
		chk({15'h0000, rsp.rd_valid}, 16'h0000);
		host.rd(8'h02, w, h, v);
		chk(w, 16'h0000);
		chk({14'h0000, v, h}, 16'h0002);
		@(posedge clk_sys_in);
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		rstn_in <= 1'b1;
		#1;
		chk({8'h00, ptr}, 16'h0000);
		chk(rsp.rdata, 16'h0000);
		chk({14'h0000, rsp.rd_valid, rsp.id_hit}, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			host.rd_same(8'hfb + 8'(i), w, h, v);
			chk(w, exp_w[i]);
			chk({14'h0000, v, h}, 16'h0003);
		end
		host.rd_same(8'h01, w, h, v);
		chk(w, 16'h0000);
		chk({14'h0000, v, h}, 16'h0002);
		print_verdict();
	end
endmodule // sidr_bank_tb
